// File: pkg/mjc_consts.vh
/*
 Constants for the measurement start/stop and judgment block.
 Assumes one 100 MHz sample clock and signed 16-bit load, displacement and limit values.
*/
// Overview of operation
// R1: External start mode begins on control-input edge or operator start.
// R2: Combined start waits for external start, then load/travel above start level.
// R3: Force rising/falling modes start on crossing; re-arm in standby afterwards.
// R4: Travel rising/falling modes start on crossing; re-arm in standby afterwards.
// R5: External stop mode ends on control-input edge or operator stop.
// R6: Force stop: exceed level if start load at/below, else fall to level.
// R7: Travel stop: external stop or travel crossing the stop level.
// R8: Timeout stop: external stop or configured duration elapsed.
// R9: Full-scale X value always forces the end of measurement.
// R10: Force reset, clear or operator reset abort and discard measurement.
// R11: X origin zeroed at start: time from zero, travel from zero.
// R12: Combined travel start keeps travel values without re-zeroing.
// R13: Continuous judgment from power-up, suspended while measuring, resumed by clear.
// R14: Continuous judgment drives the four limit flags against indicator value.
// R15: Band judgment starts past start point, finalised past end point.
// R16: Band high/low flags latch and stop band judgment.
// R17: Band OK when load stayed within low and high limits inclusive.
// R18: Zone-switch input advances through enabled zones in ascending order.
// R19: Zone compares live load or held value; high and low may coexist.
// R20: Zone OK only when every enabled zone judged OK.
// R21: Five zones, each enabled separately with its own hold method.
// R22: Sampling hold captures value on zone entry, releases on exit.
// R23: Load OK needs both band and zone OK when combined.
// R24: Control inputs synchronised and acted on at rising edges.
`ifndef MJC_CONSTS_VH
`define MJC_CONSTS_VH
`define DW           16
`define NZ           5
`define ZW           3
`define SM_EXT       3'h0
`define SM_EXT_FORCE 3'h1
`define SM_EXT_TRAV  3'h2
`define SM_FORCE_UP  3'h3
`define SM_FORCE_DN  3'h4
`define SM_TRAV_UP   3'h5
`define SM_TRAV_DN   3'h6
`define PM_EXT       2'h0
`define PM_FORCE     2'h1
`define PM_TRAV      2'h2
`define PM_TIMEOUT   2'h3
`define HM_SAMPLE    1'b1
`define MS_NS        1000000
`define CLK_NS       10
`define PS_W         17
`define IN_SS        0
`define IN_FR        1
`define IN_CL        2
`define IN_ZS        3
`define SYNC_RST     4'h0
`define VAL_RST      16'h0000
`define ZV_RST       5'h00
`define ZI_RST       3'h0
`endif

// File: hw/measurement_judgment_control.v
/*
 Measurement start/stop control with continuous, band and five-zone judgment.
 Assumes LOAD and DISP are fresh samples every clock on CLK; control pins are
 asynchronous; operator commands are one-cycle pulses on CLK; settings are static.
*/
`timescale 1ns/1ps
`include "mjc_consts.vh"
module measurement_judgment_control #(
  parameter MS_CYCLES = `MS_NS / `CLK_NS
) (
  // Clock and reset
  input  wire                       CLK,
  input  wire                       SYS_RST,
  // Control connector pins
  input  wire                       START_STOP,
  input  wire                       FORCE_RESET,
  input  wire                       CLEAR_RESULTS,
  input  wire                       ZONE_SWITCH,
  // Operator commands
  input  wire                       START_CMD,
  input  wire                       STOP_CMD,
  input  wire                       RESET_CMD,
  // Sensor samples
  input  wire signed [`DW-1:0]      LOAD,
  input  wire signed [`DW-1:0]      DISP,
  // Start/stop settings
  input  wire [2:0]                 START_MODE,
  input  wire [1:0]                 STOP_MODE,
  input  wire                       X_IS_DISP,
  input  wire signed [`DW-1:0]      START_LEVEL,
  input  wire signed [`DW-1:0]      STOP_LEVEL,
  input  wire signed [`DW-1:0]      STOP_TIME_MS,
  input  wire signed [`DW-1:0]      X_FULL_SCALE,
  // Continuous limits
  input  wire signed [`DW-1:0]      LIM_HH,
  input  wire signed [`DW-1:0]      LIM_HI,
  input  wire signed [`DW-1:0]      LIM_LO,
  input  wire signed [`DW-1:0]      LIM_LL,
  // Band settings
  input  wire                       BAND_EN,
  input  wire signed [`DW-1:0]      BAND_X_START,
  input  wire signed [`DW-1:0]      BAND_X_END,
  input  wire signed [`DW-1:0]      BAND_HI,
  input  wire signed [`DW-1:0]      BAND_LO,
  // Zone settings, zone n in bits n*16 upward
  input  wire                       INPUT_DRIVEN_ZONE_SELECT,
  input  wire [`NZ-1:0]             ZONE_EN,
  input  wire [`NZ-1:0]             ZONE_METHOD,
  input  wire [`NZ*`DW-1:0]         ZONE_X_LO,
  input  wire [`NZ*`DW-1:0]         ZONE_X_HI,
  input  wire [`NZ*`DW-1:0]         ZONE_HI,
  input  wire [`NZ*`DW-1:0]         ZONE_LO,
  // Status
  output wire                       MEASURING,
  output wire                       STANDBY,
  output reg                        MEAS_DONE,
  output reg                        DATA_DISCARD,
  output reg  signed [`DW-1:0]      X_VALUE,
  output reg  [`ZW-1:0]             ACTIVE_ZONE,
  // Judgment
  output reg                        UPPER_ALARM_FLAG,
  output reg                        UPPER_LIMIT_FLAG,
  output reg                        UNDER_MIN_FLAG,
  output reg                        BOTTOM_ALARM_FLAG,
  output reg                        BAND_OK,
  output wire [`NZ-1:0]             ZONE_HI_FLAGS,
  output wire [`NZ-1:0]             ZONE_LO_FLAGS,
  output reg                        ZONE_OK,
  output reg                        LOAD_OK
);

  localparam S_IDLE = 2'b00;
  localparam S_WAIT = 2'b01;
  localparam S_MEAS = 2'b10;
  localparam S_DONE = 2'b11;

  reg  [1:0]            state_r;
  reg  [1:0]            state_nxt;
  reg  [3:0]            meta_r;
  reg  [3:0]            sync_r;
  reg  [3:0]            prev_r;
  reg  signed [`DW-1:0] load_prev_r;
  reg  signed [`DW-1:0] disp_prev_r;
  reg  signed [`DW-1:0] origin_r;
  reg  signed [`DW-1:0] start_load_r;
  reg  signed [`DW-1:0] start_disp_r;
  reg  signed [`DW-1:0] elapsed_r;
  reg  [`PS_W-1:0]      presc_r;
  reg                   band_act_r;
  reg                   band_fin_r;
  reg                   band_hi_r;
  reg                   band_lo_r;
  reg                   go;
  reg                   stop_hit;
  wire [3:0]            rise;
  wire                  ext_start;
  wire                  ext_stop;
  wire                  abort;
  wire                  level_mode;
  wire                  combined;
  wire                  start_p;
  wire                  meas;
  wire signed [`DW-1:0] x_now;
  wire [`NZ-1:0]        zone_good;
  wire                  zones_ok;

  // R24 pin synchroniser
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      meta_r <= `SYNC_RST;
      sync_r <= `SYNC_RST;
      prev_r <= `SYNC_RST;
    end else begin
      meta_r <= {ZONE_SWITCH, CLEAR_RESULTS, FORCE_RESET, START_STOP};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // R24 rising edges only
  assign rise      = sync_r & ~prev_r;
  assign ext_start = rise[`IN_SS] | START_CMD;
  assign ext_stop  = rise[`IN_SS] | STOP_CMD;
  // R10 abort sources
  assign abort     = rise[`IN_FR] | rise[`IN_CL] | RESET_CMD;
  assign combined  = (START_MODE == `SM_EXT_FORCE) | (START_MODE == `SM_EXT_TRAV);
  assign level_mode = (START_MODE != `SM_EXT) & ~combined;
  assign meas      = (state_r == S_MEAS);
  assign MEASURING = meas;
  assign STANDBY   = (state_r == S_WAIT) | (~meas & level_mode);
  assign start_p   = ~meas & (state_nxt == S_MEAS);

  // R11 time or travel from zero
  assign x_now = X_IS_DISP ? DISP - origin_r : elapsed_r;

  always @* begin
    go = 1'b0;
    case (START_MODE)
      // R1 external start
      `SM_EXT:       go = ext_start;
      // R2 level after external
      `SM_EXT_FORCE: go = LOAD > START_LEVEL;
      `SM_EXT_TRAV:  go = DISP > START_LEVEL;
      // R3 force crossing
      `SM_FORCE_UP:  go = (LOAD > START_LEVEL) & (load_prev_r <= START_LEVEL);
      `SM_FORCE_DN:  go = (LOAD < START_LEVEL) & (load_prev_r >= START_LEVEL);
      // R4 travel crossing
      `SM_TRAV_UP:   go = (DISP > START_LEVEL) & (disp_prev_r <= START_LEVEL);
      `SM_TRAV_DN:   go = (DISP < START_LEVEL) & (disp_prev_r >= START_LEVEL);
      default:       go = 1'b0;
    endcase
  end

  always @* begin
    // R5 external stop
    stop_hit = ext_stop;
    case (STOP_MODE)
      // R6 direction from start load
      `PM_FORCE: stop_hit = ext_stop | ((start_load_r <= STOP_LEVEL) ?
                                        (LOAD > STOP_LEVEL) : (LOAD <= STOP_LEVEL));
      // R7 travel crossing
      `PM_TRAV:  stop_hit = ext_stop | ((start_disp_r <= STOP_LEVEL) ?
                                        (DISP > STOP_LEVEL) : (DISP <= STOP_LEVEL));
      // R8 duration elapsed
      `PM_TIMEOUT: stop_hit = ext_stop | (elapsed_r >= STOP_TIME_MS);
      default:   stop_hit = ext_stop;
    endcase
    // R9 full scale
    if (x_now >= X_FULL_SCALE)
      stop_hit = 1'b1;
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (combined & ext_start)
          state_nxt = S_WAIT;
        else if (~combined & go)
          state_nxt = S_MEAS;
      end
      S_WAIT: begin
        if (abort)
          state_nxt = S_IDLE;
        else if (go)
          state_nxt = S_MEAS;
      end
      S_MEAS: begin
        if (abort)
          state_nxt = S_IDLE;
        else if (stop_hit)
          state_nxt = S_DONE;
      end
      S_DONE: begin
        // R13 resume continuous on clear
        if (abort)
          state_nxt = S_IDLE;
        // R3 re-arm in standby
        else if (level_mode & go)
          state_nxt = S_MEAS;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r      <= S_IDLE;
      load_prev_r  <= `VAL_RST;
      disp_prev_r  <= `VAL_RST;
      origin_r     <= `VAL_RST;
      start_load_r <= `VAL_RST;
      start_disp_r <= `VAL_RST;
      elapsed_r    <= `VAL_RST;
      presc_r      <= {`PS_W{1'b0}};
      MEAS_DONE    <= 1'b0;
      DATA_DISCARD <= 1'b0;
      X_VALUE      <= `VAL_RST;
    end else begin
      state_r      <= state_nxt;
      load_prev_r  <= LOAD;
      disp_prev_r  <= DISP;
      MEAS_DONE    <= meas & ~abort & stop_hit;
      // R10 discard collected data
      DATA_DISCARD <= (meas | (state_r == S_WAIT)) & abort;
      X_VALUE      <= start_p ? `VAL_RST : x_now;
      if (start_p) begin
        // R12 keep travel values
        origin_r     <= (START_MODE == `SM_EXT_TRAV) ? `VAL_RST : DISP;
        start_load_r <= LOAD;
        start_disp_r <= DISP;
        elapsed_r    <= `VAL_RST;
        presc_r      <= {`PS_W{1'b0}};
      end else if (meas) begin
        if (presc_r == MS_CYCLES - 1) begin
          presc_r <= {`PS_W{1'b0}};
          // Saturate so the full-scale compare never wraps negative
          if (elapsed_r != {1'b0, {(`DW-1){1'b1}}})
            elapsed_r <= elapsed_r + 1'b1;
        end else begin
          presc_r <= presc_r + 1'b1;
        end
      end
    end
  end

  // Band judgment
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      band_act_r <= 1'b0;
      band_fin_r <= 1'b0;
      band_hi_r  <= 1'b0;
      band_lo_r  <= 1'b0;
      BAND_OK    <= 1'b0;
    end else if (start_p | (state_nxt == S_IDLE)) begin
      band_act_r <= 1'b0;
      band_fin_r <= 1'b0;
      band_hi_r  <= 1'b0;
      band_lo_r  <= 1'b0;
      BAND_OK    <= 1'b0;
    end else if (meas & BAND_EN & ~band_fin_r) begin
      // R15 start point passed
      if (x_now > BAND_X_START)
        band_act_r <= 1'b1;
      // R16 latch and cease
      if ((band_act_r | (x_now > BAND_X_START)) & ~band_hi_r & ~band_lo_r) begin
        if (LOAD > BAND_HI)
          band_hi_r <= 1'b1;
        if (LOAD < BAND_LO)
          band_lo_r <= 1'b1;
      end
      // R15 finalise at end point or stop
      if (band_act_r & ((x_now > BAND_X_END) | stop_hit)) begin
        band_fin_r <= 1'b1;
        // R17 inclusive window held
        BAND_OK    <= ~band_hi_r & ~band_lo_r & (LOAD <= BAND_HI) & (LOAD >= BAND_LO);
      end
    end
  end

  // R13 continuous only when idle, band shown otherwise
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      UPPER_ALARM_FLAG  <= 1'b0;
      UPPER_LIMIT_FLAG  <= 1'b0;
      UNDER_MIN_FLAG    <= 1'b0;
      BOTTOM_ALARM_FLAG <= 1'b0;
    end else if (state_r == S_IDLE) begin
      // R14 four-limit compare
      UPPER_ALARM_FLAG  <= LOAD > LIM_HH;
      UPPER_LIMIT_FLAG  <= LOAD > LIM_HI;
      UNDER_MIN_FLAG    <= LOAD < LIM_LO;
      BOTTOM_ALARM_FLAG <= LOAD < LIM_LL;
    end else begin
      UPPER_ALARM_FLAG  <= 1'b0;
      UPPER_LIMIT_FLAG  <= band_hi_r;
      UNDER_MIN_FLAG    <= band_lo_r;
      BOTTOM_ALARM_FLAG <= 1'b0;
    end
  end

  function [`ZW-1:0] pick_zone;
    input [`NZ-1:0] en;
    input [`ZW-1:0] cur;
    input           first;
    integer         k;
    reg             found;
    begin
      pick_zone = cur;
      found = 1'b0;
      for (k = 0; k < `NZ; k = k + 1) begin
        if (~found & en[k] & (first | (k > cur))) begin
          pick_zone = k[`ZW-1:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  // R18 ascending enabled zones
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
      ACTIVE_ZONE <= `ZI_RST;
    else if (start_p)
      ACTIVE_ZONE <= pick_zone(ZONE_EN, `ZI_RST, 1'b1);
    else if (meas & rise[`IN_ZS])
      ACTIVE_ZONE <= pick_zone(ZONE_EN, ACTIVE_ZONE, 1'b0);
  end

  // R21 five independent zones
  genvar i;
  generate
    for (i = 0; i < `NZ; i = i + 1) begin : g_zone
      wire signed [`DW-1:0] xl = ZONE_X_LO[i*`DW +: `DW];
      wire signed [`DW-1:0] xh = ZONE_X_HI[i*`DW +: `DW];
      wire signed [`DW-1:0] hl = ZONE_HI[i*`DW +: `DW];
      wire signed [`DW-1:0] ll = ZONE_LO[i*`DW +: `DW];
      wire signed [`DW-1:0] cmp;
      wire                  inz;
      wire                  act;
      reg                   in_r;
      reg                   seen_r;
      reg                   hi_r;
      reg                   lo_r;
      reg  signed [`DW-1:0] hold_r;
      assign inz = INPUT_DRIVEN_ZONE_SELECT ? (ACTIVE_ZONE == i) :
                   ((x_now >= xl) & (x_now <= xh));
      assign act = meas & ZONE_EN[i] & inz;
      // R22 held entry sample while inside, else live load
      assign cmp = (ZONE_METHOD[i] != `HM_SAMPLE) ? LOAD : (in_r ? hold_r : LOAD);
      always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          in_r   <= 1'b0;
          seen_r <= 1'b0;
          hi_r   <= 1'b0;
          lo_r   <= 1'b0;
          hold_r <= `VAL_RST;
        end else if (start_p | (state_nxt == S_IDLE)) begin
          in_r   <= 1'b0;
          seen_r <= 1'b0;
          hi_r   <= 1'b0;
          lo_r   <= 1'b0;
        end else begin
          // R22 released on leaving
          in_r <= act;
          if (act & ~in_r)
            hold_r <= LOAD;
          if (act) begin
            seen_r <= 1'b1;
            // R19 both flags may set
            if (cmp > hl)
              hi_r <= 1'b1;
            if (cmp < ll)
              lo_r <= 1'b1;
          end
        end
      end
      assign ZONE_HI_FLAGS[i] = hi_r;
      assign ZONE_LO_FLAGS[i] = lo_r;
      assign zone_good[i] = ~ZONE_EN[i] | (seen_r & ~hi_r & ~lo_r);
    end
  endgenerate

  // R20 all enabled zones OK
  assign zones_ok = (&zone_good) & (|ZONE_EN);

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ZONE_OK <= 1'b0;
      LOAD_OK <= 1'b0;
    end else begin
      ZONE_OK <= zones_ok;
      // R23 band and zones combined
      if (BAND_EN & (|ZONE_EN))
        LOAD_OK <= BAND_OK & zones_ok;
      else if (BAND_EN)
        LOAD_OK <= BAND_OK;
      else
        LOAD_OK <= zones_ok;
    end
  end

endmodule // measurement_judgment_control

// File: test/mjc_checker_properties.sv
/* Concurrent checks on the measurement start/stop and judgment block.
   Assumes it is bound to the block's top module and sees its ports only. */
`timescale 1ns/1ps
`include "mjc_consts.vh"
module mjc_checker (
  // Clock and reset
  input wire                  CLK,
  input wire                  SYS_RST,
  // Commands and settings
  input wire                  START_CMD,
  input wire                  STOP_CMD,
  input wire                  RESET_CMD,
  input wire signed [`DW-1:0] LOAD,
  input wire [2:0]            START_MODE,
  input wire [1:0]            STOP_MODE,
  input wire                  X_IS_DISP,
  input wire signed [`DW-1:0] STOP_TIME_MS,
  input wire signed [`DW-1:0] X_FULL_SCALE,
  input wire signed [`DW-1:0] LIM_HH,
  input wire signed [`DW-1:0] LIM_HI,
  input wire signed [`DW-1:0] LIM_LO,
  input wire signed [`DW-1:0] LIM_LL,
  input wire                  BAND_EN,
  input wire [`NZ-1:0]        ZONE_EN,
  // Status and judgment
  input wire                  MEASURING,
  input wire                  STANDBY,
  input wire                  MEAS_DONE,
  input wire                  DATA_DISCARD,
  input wire signed [`DW-1:0] X_VALUE,
  input wire                  UPPER_ALARM_FLAG,
  input wire                  UPPER_LIMIT_FLAG,
  input wire                  UNDER_MIN_FLAG,
  input wire                  BOTTOM_ALARM_FLAG,
  input wire                  BAND_OK,
  input wire [`NZ-1:0]        ZONE_HI_FLAGS,
  input wire [`NZ-1:0]        ZONE_LO_FLAGS,
  input wire                  ZONE_OK,
  input wire                  LOAD_OK
);
  reg up_r;
  reg cont_r;

  // Idle tracker; it lags the block by a cycle, so checks need it set twice
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      up_r   <= 1'b0;
      cont_r <= 1'b0;
    end else begin
      up_r <= 1'b1;
      if (MEASURING || STANDBY)
        cont_r <= 1'b0;
      else if (RESET_CMD || DATA_DISCARD || !up_r)
        cont_r <= 1'b1;
    end
  end

  default clocking dc @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_cont_high: assert property (cont_r && $past(cont_r) |->
    UPPER_ALARM_FLAG == ($past(LOAD) > $past(LIM_HH)) &&
    UPPER_LIMIT_FLAG == ($past(LOAD) > $past(LIM_HI))) else $error("high flags wrong");
  a_cont_low: assert property (cont_r && $past(cont_r) |->
    UNDER_MIN_FLAG == ($past(LOAD) < $past(LIM_LO)) &&
    BOTTOM_ALARM_FLAG == ($past(LOAD) < $past(LIM_LL))) else $error("low flags wrong");
  a_ext_start: assert property (cont_r && !MEASURING && START_CMD && !STOP_CMD &&
    !RESET_CMD && START_MODE == `SM_EXT |=> MEASURING) else $error("start missed");
  a_stop_done: assert property (MEASURING && STOP_CMD && !RESET_CMD |=>
    !MEASURING && MEAS_DONE) else $error("stop missed");
  a_abort_discard: assert property (MEASURING && RESET_CMD |=>
    !MEASURING && DATA_DISCARD) else $error("abort missed");
  a_x_origin: assert property ($rose(MEASURING) &&
    !(X_IS_DISP && START_MODE == `SM_EXT_TRAV) |-> X_VALUE == 16'h0000)
    else $error("origin not zero");
  a_time_stop: assert property (MEASURING && STOP_MODE == `PM_TIMEOUT && !X_IS_DISP &&
    X_VALUE >= STOP_TIME_MS |-> ##[1:2] !MEASURING) else $error("time stop late");
  a_full_scale: assert property (MEASURING && X_VALUE >= X_FULL_SCALE |->
    ##[1:2] !MEASURING) else $error("full scale stop late");
  a_zone_ok: assert property (ZONE_OK |-> ZONE_EN != 5'h00 &&
    (($past(ZONE_HI_FLAGS) | $past(ZONE_LO_FLAGS)) & ZONE_EN) == 5'h00)
    else $error("zone ok with a flag");
  a_load_ok: assert property (LOAD_OK && BAND_EN |-> $past(BAND_OK))
    else $error("load ok without band ok");
  a_band_latch: assert property (MEASURING && $past(MEASURING) && BAND_EN &&
    UPPER_LIMIT_FLAG && !RESET_CMD |=> UPPER_LIMIT_FLAG) else $error("band flag dropped");

  c_stop: cover property (MEAS_DONE);
  c_abort: cover property (DATA_DISCARD);
  c_load_ok: cover property (LOAD_OK);
endmodule // mjc_checker

bind measurement_judgment_control mjc_checker chk_u (
  .CLK(CLK), .SYS_RST(SYS_RST), .START_CMD(START_CMD), .STOP_CMD(STOP_CMD),
  .RESET_CMD(RESET_CMD), .LOAD(LOAD), .START_MODE(START_MODE), .STOP_MODE(STOP_MODE),
  .X_IS_DISP(X_IS_DISP), .STOP_TIME_MS(STOP_TIME_MS), .X_FULL_SCALE(X_FULL_SCALE),
  .LIM_HH(LIM_HH), .LIM_HI(LIM_HI), .LIM_LO(LIM_LO), .LIM_LL(LIM_LL), .BAND_EN(BAND_EN),
  .ZONE_EN(ZONE_EN), .MEASURING(MEASURING), .STANDBY(STANDBY), .MEAS_DONE(MEAS_DONE),
  .DATA_DISCARD(DATA_DISCARD), .X_VALUE(X_VALUE), .UPPER_ALARM_FLAG(UPPER_ALARM_FLAG),
  .UPPER_LIMIT_FLAG(UPPER_LIMIT_FLAG), .UNDER_MIN_FLAG(UNDER_MIN_FLAG),
  .BOTTOM_ALARM_FLAG(BOTTOM_ALARM_FLAG), .BAND_OK(BAND_OK), .ZONE_HI_FLAGS(ZONE_HI_FLAGS),
  .ZONE_LO_FLAGS(ZONE_LO_FLAGS), .ZONE_OK(ZONE_OK), .LOAD_OK(LOAD_OK));

// File: test/sensor_model.sv
/* Sensor front end for the bench: load follows a set value, travel ramps.
   Assumes the bench changes set_load and step just after a rising edge. */
`timescale 1ns/1ps
`include "mjc_consts.vh"
module sensor_model (
  // Clock and reset
  input  wire                  clk,
  input  wire                  rst,
  // Bench settings
  input  wire signed [`DW-1:0] set_load,
  input  wire signed [`DW-1:0] step,
  // Samples
  output reg  signed [`DW-1:0] load,
  output reg  signed [`DW-1:0] disp
);
  // A fresh sample every clock, as the block expects
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      load <= 16'sh0000;
      disp <= 16'sh0000;
    end else begin
      load <= set_load;
      disp <= disp + step;
    end
  end
endmodule // sensor_model

// File: test/tb_measurement_judgment_control.sv
/* Self-checking bench for the measurement start/stop and judgment block.
   Assumes MS_CYCLES of 4, so one millisecond of X is four clocks. */
`timescale 1ns/1ps
`include "mjc_consts.vh"
module tb_measurement_judgment_control;
  logic CLK, SYS_RST, START_STOP, FORCE_RESET, CLEAR_RESULTS, ZONE_SWITCH;
  logic START_CMD, STOP_CMD, RESET_CMD, X_IS_DISP, BAND_EN, INPUT_DRIVEN_ZONE_SELECT;
  logic [2:0] START_MODE;
  logic [1:0] STOP_MODE;
  logic [4:0] ZONE_EN, ZONE_METHOD;
  logic [79:0] ZONE_X_LO, ZONE_X_HI, ZONE_HI, ZONE_LO;
  logic signed [15:0] START_LEVEL, STOP_LEVEL, STOP_TIME_MS, X_FULL_SCALE, set_load, step;
  logic signed [15:0] LIM_HH, LIM_HI, LIM_LO, LIM_LL, BAND_X_START, BAND_X_END, BAND_HI, BAND_LO;
  wire signed [15:0] LOAD, DISP, X_VALUE;
  wire MEASURING, STANDBY, MEAS_DONE, DATA_DISCARD, BAND_OK, ZONE_OK, LOAD_OK;
  wire UPPER_ALARM_FLAG, UPPER_LIMIT_FLAG, UNDER_MIN_FLAG, BOTTOM_ALARM_FLAG;
  wire [2:0] ACTIVE_ZONE;
  wire [4:0] ZONE_HI_FLAGS, ZONE_LO_FLAGS;
  logic done_seen, discard_seen;
  int total_checks, n_mismatch;
  logic [15:0] cl [5] = '{16'h01c2, 16'h0190, 16'h0064, 16'h0000, 16'hfff6};
  logic [3:0] cf [5] = '{4'hc, 4'h4, 4'h0, 4'h2, 4'h3};

  measurement_judgment_control #(.MS_CYCLES(4)) dut_u (.*);
  sensor_model snd_u (.clk(CLK), .rst(SYS_RST), .set_load(set_load), .step(step),
    .load(LOAD), .disp(DISP));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Pulses are one cycle wide, so catch them as they rise
  always @(posedge MEAS_DONE) done_seen = 1'b1;
  always @(posedge DATA_DISCARD) discard_seen = 1'b1;

  task chk(input logic [16:0] got, input logic [16:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task cmd(input logic [2:0] k);
    {done_seen, discard_seen} = 2'b00;
    @(posedge CLK);
    {RESET_CMD, STOP_CMD, START_CMD} <= k;
    @(posedge CLK);
    {RESET_CMD, STOP_CMD, START_CMD} <= 3'h0;
    #1;
  endtask
  // Pins pass a two-stage synchroniser; hold long enough to be seen
  task pin(input logic [3:0] k);
    {done_seen, discard_seen} = 2'b00;
    @(posedge CLK);
    {ZONE_SWITCH, CLEAR_RESULTS, FORCE_RESET, START_STOP} <= k;
    repeat (4) @(posedge CLK);
    {ZONE_SWITCH, CLEAR_RESULTS, FORCE_RESET, START_STOP} <= 4'h0;
    tick(1);
  endtask
  task waitm(input logic v, input int n);
    int i;
    i = 0;
    while (MEASURING !== v && i < n) begin
      @(posedge CLK);
      #1;
      i++;
    end
    chk(MEASURING, v, "measuring state");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run is well under a thousand cycles; this bound is ten times that
  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end

  initial begin
    {START_STOP, FORCE_RESET, CLEAR_RESULTS, ZONE_SWITCH} = 4'h0;
    {START_CMD, STOP_CMD, RESET_CMD, X_IS_DISP, BAND_EN, INPUT_DRIVEN_ZONE_SELECT} = 6'h00;
    {START_MODE, STOP_MODE, ZONE_EN, ZONE_METHOD} = 15'h0000;
    {START_LEVEL, STOP_LEVEL, STOP_TIME_MS, X_FULL_SCALE} = {16'h0064, 16'h0032, 16'h7fff, 16'h7fff};
    {LIM_HH, LIM_HI, LIM_LO, LIM_LL} = {16'h0190, 16'h012c, 16'h0064, 16'h0000};
    {BAND_X_START, BAND_X_END, BAND_HI, BAND_LO} = {16'h0001, 16'h0005, 16'h012c, 16'h0064};
    {ZONE_X_LO, ZONE_X_HI, ZONE_HI, ZONE_LO} = {80'h1, 80'h4, 80'h12c, 80'h64};
    {set_load, step, done_seen, discard_seen} = {16'h00c8, 16'h0000, 2'b00};
    SYS_RST = 1'b1;
    repeat (5) @(posedge CLK);
    SYS_RST <= 1'b0;
    tick(3);
    cmd(3'h1);
    chk({MEASURING, X_VALUE}, 17'h10000, "start at zero");
    tick(6);
    cmd(3'h2);
    chk({MEASURING, done_seen}, 2'b01, "operator stop");
    @(posedge CLK);
    set_load <= 16'h01c2;
    tick(4);
    chk(UPPER_ALARM_FLAG, 1'b0, "suspended after stop");
    cmd(3'h4);
    for (int i = 0; i < 5; i++) begin
      @(posedge CLK);
      set_load <= cl[i];
      tick(4);
      chk({UPPER_ALARM_FLAG, UPPER_LIMIT_FLAG, UNDER_MIN_FLAG, BOTTOM_ALARM_FLAG}, cf[i], "cont");
    end
    pin(4'h1);
    chk(MEASURING, 1'b1, "pin start");
    pin(4'h1);
    chk(MEASURING, 1'b0, "pin stop");
    cmd(3'h4);
    for (int i = 0; i < 3; i++) begin
      cmd(3'h1);
      if (i < 2) pin(i ? 4'h4 : 4'h2); else cmd(3'h4);
      chk({MEASURING, discard_seen}, 2'b01, "abort");
    end
    @(posedge CLK);
    {STOP_MODE, STOP_TIME_MS} <= {`PM_TIMEOUT, 16'h0003};
    cmd(3'h1);
    tick(9);
    chk(MEASURING, 1'b1, "before time limit");
    waitm(1'b0, 6);
    chk(done_seen, 1'b1, "time limit stop");
    cmd(3'h4);
    @(posedge CLK);
    {STOP_MODE, START_MODE, X_IS_DISP, X_FULL_SCALE} <= {`PM_EXT, `SM_TRAV_UP, 1'b1, 16'h0014};
    step <= 16'h0005;
    tick(2);
    chk({MEASURING, STANDBY}, 2'b01, "travel armed");
    waitm(1'b1, 30);
    chk(X_VALUE, 16'h0000, "travel origin");
    waitm(1'b0, 8);
    chk({done_seen, STANDBY}, 2'b11, "full scale and rearm");
    @(posedge CLK);
    {step, X_FULL_SCALE, START_MODE} <= {16'h0000, 16'h7fff, `SM_EXT_TRAV};
    cmd(3'h4);
    cmd(3'h1);
    waitm(1'b1, 4);
    tick(2);
    chk(X_VALUE, DISP, "travel kept");
    cmd(3'h4);
    @(posedge CLK);
    {START_MODE, X_IS_DISP, set_load} <= {`SM_EXT_FORCE, 1'b0, 16'h0032};
    cmd(3'h1);
    tick(3);
    chk({MEASURING, STANDBY}, 2'b01, "waiting for load");
    @(posedge CLK);
    set_load <= 16'h0096;
    waitm(1'b1, 4);
    cmd(3'h4);
    @(posedge CLK);
    {START_MODE, STOP_MODE, STOP_LEVEL, set_load} <= {`SM_FORCE_UP, `PM_FORCE, 16'h00c8, 16'h0032};
    tick(3);
    @(posedge CLK);
    set_load <= 16'h0096;
    waitm(1'b1, 4);
    tick(4);
    chk(MEASURING, 1'b1, "below stop level");
    @(posedge CLK);
    set_load <= 16'h00fa;
    waitm(1'b0, 4);
    chk({done_seen, STANDBY}, 2'b11, "load stop and rearm");
    @(posedge CLK);
    {START_MODE, STOP_MODE, X_FULL_SCALE, BAND_EN, ZONE_EN} <= {`SM_EXT, `PM_EXT, 16'h0008, 6'h21};
    cmd(3'h4);
    for (int r = 0; r < 2; r++) begin
      @(posedge CLK);
      set_load <= r ? 16'h015e : 16'h012c;
      cmd(3'h1);
      waitm(1'b0, 45);
      tick(3);
      chk({BAND_OK, ZONE_OK, LOAD_OK}, r ? 3'h0 : 3'h7, "verdicts");
      chk({UPPER_LIMIT_FLAG, ZONE_HI_FLAGS[0], ZONE_LO_FLAGS[0]}, r ? 3'h6 : 3'h0, "hi");
      cmd(3'h4);
    end
    @(posedge CLK);
    {INPUT_DRIVEN_ZONE_SELECT, ZONE_EN, X_FULL_SCALE} <= {1'b1, 5'h16, 16'h7fff};
    cmd(3'h1);
    for (int z = 0; z < 4; z++) begin
      if (z > 0) pin(4'h8);
      tick(2);
      chk(ACTIVE_ZONE, (z == 0) ? 3'h1 : (z == 1) ? 3'h2 : 3'h4, "zone step");
    end
    cmd(3'h2);
    test_done;
  end
endmodule // tb_measurement_judgment_control
